// [core/mpr_consts.svh]
// Constants for the motion pause and resume control block
// Contract
// - Pause of moves decelerates, never stops abruptly
// - Pause halts motion only, sequence keeps running
// - Remaining travel kept and later resumed
// - Start input resumes in sequence, select zero
// - Linked or homing moves: soft stop, resume ignored
// - Paused until resume, clear, or new motion
// - Pause sets status flag and assigned output
// - Pause with no motion is ignored
// - Pause pin or remote input when assigned
// - Clear discards remaining travel without restart
// - Motion end withheld while paused
// - Clear in sequence ends motion, sequence proceeds
`ifndef MPR_CONSTS_SVH
`define MPR_CONSTS_SVH
// ----------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------
`define MPR_OFS_CTRL     12'h000
`define MPR_OFS_STATUS   12'h004
`define MPR_OFS_REMAIN   12'h008
`define MPR_OFS_INT_STAT 12'h00c
`define MPR_OFS_INT_CLR  12'h010
`define MPR_OFS_INT_EN   12'h014
// ----------------------------------------------------------
// Control fields
// ----------------------------------------------------------
`define MPR_CTRL_START_SEL 0
`define MPR_CTRL_PIN_ASG   1
`define MPR_CTRL_RMT_ASG   2
`define MPR_CTRL_OUT_ASG   3
`define MPR_CTRL_RATE_LSB  8
`define MPR_CTRL_RATE_MSB  15
`define MPR_CTRL_RESET     32'h0000_0000
// ----------------------------------------------------------
// Interrupt event bits
// ----------------------------------------------------------
`define MPR_EV_PAUSED  0
`define MPR_EV_RESUMED 1
`define MPR_EV_CLEARED 2
`define MPR_EV_IGNORED 3
`define MPR_EV_W       4
`endif

// [core/mpr_pkg.sv]
// Types shared by the motion pause and resume control block
package mpr_pkg;
  // Kind of motion that the motion engine is running
  typedef enum logic [2:0] {
    MPR_MOVE_INCREMENTAL = 3'h0,
    MPR_MOVE_ABSOLUTE    = 3'h1,
    MPR_MOVE_RESUME_MOTION_POS    = 3'h2,
    MPR_MOVE_RESUME_MOTION_NEG    = 3'h3,
    MPR_MOVE_LINKED      = 3'h4,
    MPR_MOVE_EHOME       = 3'h5,
    MPR_MOVE_MHOME       = 3'h6
  } mpr_kind_e;
  // Control states, one-hot
  typedef enum logic [3:0] {
    MPR_IDLE     = 4'h1,
    MPR_MOVING   = 4'h2,
    MPR_STOPPING = 4'h4,
    MPR_PAUSED   = 4'h8
  } mpr_state_e;
  // Motion command seen on its way to the motion engine
  typedef struct packed {
    logic        valid;
    mpr_kind_e   kind;
    logic [31:0] travel;
  } mpr_cmd_s;
  // Restart order sent back to the motion engine
  typedef struct packed {
    logic        valid;
    mpr_kind_e   kind;
    logic [31:0] travel;
  } mpr_launch_s;
endpackage : mpr_pkg

// [core/mpr_pause_ctrl.sv]
// Pause, resume and clear control for a single-axis motion controller
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`include "mpr_consts.svh"
module mpr_pause_ctrl (
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic [31:0]              prdata,
  // Motion engine side
  input  wire mpr_pkg::mpr_cmd_s   motion_cmd,
  input  wire logic                motor_moving,
  input  wire logic                motion_done,
  input  wire logic [31:0]         engine_remain,
  output mpr_pkg::mpr_launch_s     launch,
  output logic                     soft_stop_cmd,
  output logic [7:0]               stop_rate,
  output logic                     motion_end,
  // Pause, resume, clear and start sources
  input  wire logic                pause_cmd,
  input  wire logic                pause_pin,
  input  wire logic                pause_remote,
  input  wire logic                resume_motion,
  input  wire logic                resume_pin,
  input  wire logic                clear_paused_motion,
  input  wire logic                clear_pause_input,
  input  wire logic                start_in,
  input  wire logic                seq_running,
  // Status
  output logic                     pause_status_flag,
  output logic                     pause_status_signal,
  output logic                     irq
);
  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  mpr_pkg::mpr_state_e  state_q;        // Control state
  mpr_pkg::mpr_kind_e   kind_q;         // Kind of current motion
  logic [31:0]          remain_q;       // Stored remaining travel
  logic [31:0]          ctrl_q;         // Control register
  logic [`MPR_EV_W-1:0] int_stat_q;     // Sticky events
  logic [`MPR_EV_W-1:0] int_en_q;       // Event enables
  logic [`MPR_EV_W-1:0] ev;             // Events this cycle
  logic [`MPR_EV_W-1:0] int_clr;        // Clear strobe from bus
  logic                 pin_q;          // Previous pause pin
  logic                 rmt_q;          // Previous remote pause
  logic                 res_pin_q;      // Previous resume pin
  logic                 clr_pin_q;      // Previous clear pin
  logic                 start_q;        // Previous start input
  logic                 pause_req;      // Any pause request
  logic                 resume_req;     // Any resume request
  logic                 clear_req;      // Any clear request
  logic                 resumable;      // Current kind may resume
  logic                 wr_en;          // Bus write takes effect
  logic                 setup;          // Bus setup cycle

  // ----------------------------------------------------------
  // Request decoding
  // ----------------------------------------------------------
  // Pin, remote and start inputs are levels, so a request is their rising edge; commands count while high
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_q     <= 1'b0;
      rmt_q     <= 1'b0;
      res_pin_q <= 1'b0;
      clr_pin_q <= 1'b0;
      start_q   <= 1'b0;
    end else begin
      pin_q     <= pause_pin;
      rmt_q     <= pause_remote;
      res_pin_q <= resume_pin;
      clr_pin_q <= clear_pause_input;
      start_q   <= start_in;
    end
  end

  // Unassigned pins are ignored altogether
  assign pause_req = pause_cmd
    | (pause_pin & ~pin_q & ctrl_q[`MPR_CTRL_PIN_ASG])
    | (pause_remote & ~rmt_q & ctrl_q[`MPR_CTRL_RMT_ASG]);

  // Start resumes only inside a running sequence, select zero
  assign resume_req = resume_motion | (resume_pin & ~res_pin_q)
    | (start_in & ~start_q & seq_running
       & (ctrl_q[`MPR_CTRL_START_SEL] == 1'b0));

  assign clear_req = clear_paused_motion
    | (clear_pause_input & ~clr_pin_q);

  // Only plain moves can be resumed
  assign resumable = (kind_q == mpr_pkg::MPR_MOVE_INCREMENTAL)
    | (kind_q == mpr_pkg::MPR_MOVE_ABSOLUTE)
    | (kind_q == mpr_pkg::MPR_MOVE_RESUME_MOTION_POS)
    | (kind_q == mpr_pkg::MPR_MOVE_RESUME_MOTION_NEG);

  // ----------------------------------------------------------
  // Control state machine
  // ----------------------------------------------------------
  // The sequencer is never touched here, so a pause leaves it
  // running; only the axis is stopped
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q           <= mpr_pkg::MPR_IDLE;
      kind_q            <= mpr_pkg::MPR_MOVE_INCREMENTAL;
      remain_q          <= 32'h0000_0000;
      pause_status_flag <= 1'b0;
      soft_stop_cmd     <= 1'b0;
      motion_end        <= 1'b0;
      launch            <= '0;
      ev                <= '0;
    end else begin
      soft_stop_cmd <= 1'b0;
      motion_end    <= 1'b0;
      launch.valid  <= 1'b0;
      ev            <= '0;
      case (state_q)
        mpr_pkg::MPR_IDLE: begin
          // Nothing moves, so a pause request is dropped
          if (pause_req) begin
            ev[`MPR_EV_IGNORED] <= 1'b1;
          end
          if (motion_cmd.valid) begin
            state_q <= mpr_pkg::MPR_MOVING;
            kind_q  <= motion_cmd.kind;
          end
        end
        mpr_pkg::MPR_MOVING: begin
          if (motion_done) begin
            state_q    <= mpr_pkg::MPR_IDLE;
            motion_end <= 1'b1;
          end else if (pause_req) begin
            // Controlled deceleration at soft-stop rate
            state_q       <= mpr_pkg::MPR_STOPPING;
            soft_stop_cmd <= 1'b1;
          end else if (motion_cmd.valid) begin
            kind_q <= motion_cmd.kind;
          end
        end
        mpr_pkg::MPR_STOPPING: begin
          // Wait for zero velocity before settling
          if (!motor_moving) begin
            if (resumable) begin
              state_q           <= mpr_pkg::MPR_PAUSED;
              remain_q          <= engine_remain;
              pause_status_flag <= 1'b1;
              ev[`MPR_EV_PAUSED] <= 1'b1;
            end else begin
              // Linked and homing motions simply end
              state_q    <= mpr_pkg::MPR_IDLE;
              motion_end <= 1'b1;
            end
          end
        end
        mpr_pkg::MPR_PAUSED: begin
          // No motion end leaves this state by itself
          if (pause_req) begin
            ev[`MPR_EV_IGNORED] <= 1'b1;
          end
          if (motion_cmd.valid) begin
            // A new motion replaces the paused one
            state_q           <= mpr_pkg::MPR_MOVING;
            kind_q            <= motion_cmd.kind;
            remain_q          <= 32'h0000_0000;
            pause_status_flag <= 1'b0;
            ev[`MPR_EV_CLEARED] <= 1'b1;
          end else if (clear_req) begin
            // Drop the rest, end the motion
            state_q           <= mpr_pkg::MPR_IDLE;
            remain_q          <= 32'h0000_0000;
            pause_status_flag <= 1'b0;
            motion_end        <= 1'b1;
            ev[`MPR_EV_CLEARED] <= 1'b1;
          end else if (resume_req) begin
            // Relaunch the stored remainder
            state_q           <= mpr_pkg::MPR_MOVING;
            launch.valid      <= 1'b1;
            launch.kind       <= kind_q;
            launch.travel     <= remain_q;
            pause_status_flag <= 1'b0;
            ev[`MPR_EV_RESUMED] <= 1'b1;
          end
        end
        default: begin
          state_q <= mpr_pkg::MPR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------
  // Assigned output follows the flag; rate is a copy of config
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pause_status_signal <= 1'b0;
      stop_rate           <= 8'h00;
    end else begin
      pause_status_signal <= (state_q == mpr_pkg::MPR_PAUSED)
                             & ctrl_q[`MPR_CTRL_OUT_ASG];
      stop_rate <= ctrl_q[`MPR_CTRL_RATE_MSB:`MPR_CTRL_RATE_LSB];
    end
  end

  // ----------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------
  // One wait-free access: pready rises in the first access cycle
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;

  // Handshake and read data, prepared during setup
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (setup) begin
        case (paddr)
          `MPR_OFS_CTRL:     prdata <= ctrl_q;
          `MPR_OFS_STATUS:   prdata <= {24'h00_0000, 1'b0, kind_q, state_q};
          `MPR_OFS_REMAIN:   prdata <= remain_q;
          `MPR_OFS_INT_STAT: prdata <= {28'h000_0000, int_stat_q};
          `MPR_OFS_INT_CLR:  prdata <= 32'h0000_0000;
          `MPR_OFS_INT_EN:   prdata <= {28'h000_0000, int_en_q};
          default:           pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Writable registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q   <= `MPR_CTRL_RESET;
      int_en_q <= '0;
    end else if (wr_en) begin
      if (paddr == `MPR_OFS_CTRL) begin
        ctrl_q <= pwdata;
      end
      if (paddr == `MPR_OFS_INT_EN) begin
        int_en_q <= pwdata[`MPR_EV_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------
  assign int_clr = (wr_en && paddr == `MPR_OFS_INT_CLR)
                   ? pwdata[`MPR_EV_W-1:0] : '0;

  // A new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      int_stat_q <= '0;
      irq        <= 1'b0;
    end else begin
      int_stat_q <= (int_stat_q & ~int_clr) | ev;
      irq        <= |(((int_stat_q & ~int_clr) | ev) & int_en_q);
    end
  end

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_moving_pause;
    state_q == mpr_pkg::MPR_MOVING && !motion_done && pause_req;
  endsequence
  sequence s_stopped;
    state_q == mpr_pkg::MPR_STOPPING && !motor_moving;
  endsequence
  // Paused, whatever else arrives in the same cycle
  sequence s_paused;
    state_q == mpr_pkg::MPR_PAUSED;
  endsequence
  // A resume that nothing of higher priority overrides
  sequence s_resume_taken;
    state_q == mpr_pkg::MPR_PAUSED && !motion_cmd.valid && !clear_req && resume_req;
  endsequence

  // Pause must go through a ramp, never drop the axis at once
  a_pause_soft_stop: assert property (
    s_moving_pause |=> soft_stop_cmd && state_q == mpr_pkg::MPR_STOPPING)
    else $error("Pause did not start a soft stop");
  a_pause_keeps_travel: assert property (
    s_stopped and resumable |=> remain_q == $past(engine_remain))
    else $error("Remaining travel not stored");
  a_resume_travel: assert property (
    s_resume_taken |=> launch.valid && launch.travel == $past(remain_q)
      && !pause_status_flag)
    else $error("Resume did not relaunch stored travel");
  a_start_resume: assert property (
    s_paused and (!motion_cmd.valid && !clear_req && seq_running && start_in
      && !start_q && !ctrl_q[`MPR_CTRL_START_SEL]) |=> launch.valid)
    else $error("Start did not resume paused motion");
  // Kinds that cannot resume must finish as a plain motion end
  a_linked_no_pause: assert property (
    s_stopped and !resumable
      |=> state_q == mpr_pkg::MPR_IDLE && !pause_status_flag && motion_end)
    else $error("Linked motion entered pause");
  a_pause_persists: assert property (
    s_paused and (!motion_cmd.valid && !clear_req && !resume_req)
      |=> state_q == mpr_pkg::MPR_PAUSED && pause_status_flag)
    else $error("Pause left without cause");
  // The new motion's own end is the one a waiting sequence sees
  a_new_replaces: assert property (
    s_paused and motion_cmd.valid
      |=> state_q == mpr_pkg::MPR_MOVING && !motion_end && remain_q == 32'h0000_0000)
    else $error("New motion did not replace the pause");
  a_flag_follows: assert property (
    s_stopped and resumable
      |=> pause_status_flag ##1 pause_status_signal == ctrl_q[`MPR_CTRL_OUT_ASG])
    else $error("Pause status flag not set");
  a_out_unassigned: assert property (
    !ctrl_q[`MPR_CTRL_OUT_ASG] |=> !pause_status_signal)
    else $error("Pause output driven while unassigned");
  a_idle_ignore: assert property (
    state_q == mpr_pkg::MPR_IDLE && pause_req |=> !soft_stop_cmd && !pause_status_flag)
    else $error("Pause acted with no motion");
  a_stop_needs_motion: assert property (
    state_q != mpr_pkg::MPR_MOVING |=> !soft_stop_cmd)
    else $error("Soft stop ordered with no motion");
  a_clear_discard: assert property (
    s_paused and (!motion_cmd.valid && clear_req)
      |=> remain_q == 32'h0000_0000 && !launch.valid && motion_end)
    else $error("Clear did not discard travel");
  a_no_end_paused: assert property (
    s_paused and !clear_req |=> !motion_end)
    else $error("Motion end while paused");
  // Stop rate is registered, so it trails the control word by one cycle
  a_rate_copy: assert property (
    soft_stop_cmd |-> stop_rate == $past(ctrl_q[`MPR_CTRL_RATE_MSB:`MPR_CTRL_RATE_LSB]))
    else $error("Stop rate not from configuration");
endmodule : mpr_pause_ctrl

// [tb/mpr_engine_model.sv]
// Behavioural motion engine that sits on the far side of the pause control
`timescale 1ns/1ns
module mpr_engine_model #(
  parameter int DECEL = 4  // Ramp-down count after a soft stop order; standstill comes DECEL+1 cycles after the engine samples the order
) (
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  input  wire mpr_pkg::mpr_cmd_s    motion_cmd,
  input  wire mpr_pkg::mpr_launch_s launch,
  input  wire logic                 soft_stop_cmd,
  output logic                      motor_moving,
  output logic                      motion_done,
  output logic [31:0]               engine_remain
);
  // --------------------------------------------------
  // Travel counter
  // --------------------------------------------------
  logic       stop_q;  // Decelerating after a soft stop order
  logic [7:0] slow_q;  // Cycles left in the ramp down
  // One unit of travel per cycle; the ramp holds the remainder so a resume is exact
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      motor_moving  <= 1'b0;
      motion_done   <= 1'b0;
      engine_remain <= 32'h0000_0000;
      stop_q        <= 1'b0;
      slow_q        <= 8'h00;
    end else begin
      motion_done <= 1'b0;
      if (motion_cmd.valid || launch.valid) begin
        // New or resumed motion replaces whatever was left
        motor_moving  <= 1'b1;
        stop_q        <= 1'b0;
        engine_remain <= motion_cmd.valid ? motion_cmd.travel : launch.travel;
      end else if (soft_stop_cmd && motor_moving) begin
        stop_q <= 1'b1;
        slow_q <= 8'(DECEL);
      end else if (stop_q) begin
        // Velocity reaches zero only after the ramp, never at once
        if (slow_q == 8'h00) begin
          motor_moving <= 1'b0;
          stop_q       <= 1'b0;
        end else begin
          slow_q <= slow_q - 8'h01;
        end
      end else if (motor_moving) begin
        engine_remain <= engine_remain - 32'h0000_0001;
        if (engine_remain == 32'h0000_0001) begin
          motor_moving <= 1'b0;
          motion_done  <= 1'b1;
        end
      end
    end
  end
endmodule : mpr_engine_model

// [tb/motion_pause_resume_control_test.sv]
// Self-checking bench for the pause, resume and clear control
`timescale 1ns/1ns
`include "mpr_consts.svh"
module motion_pause_resume_control_test;
  // --------------------------------------------------
  // Signals
  // --------------------------------------------------
  logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, seq_running;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, remain, last_trav, d;
  logic [7:0]           src;  // Pulsed sources, one bit each
  mpr_pkg::mpr_cmd_s    cmd;
  mpr_pkg::mpr_launch_s launch;
  logic soft_stop_cmd, motion_end, flag, status_sig, irq, moving, done;
  logic [7:0]  stop_rate;
  logic [31:0] eng_rem;
  int err_count, n_compared, n_launch, n_end, n_stop, cyc, l0, e0, s0;
  // Register reset rows: address, value, slave error
  logic [44:0] rows [7] = '{{`MPR_OFS_CTRL, 32'h0, 1'b0}, {`MPR_OFS_STATUS, 32'h1, 1'b0},
    {`MPR_OFS_REMAIN, 32'h0, 1'b0}, {`MPR_OFS_INT_STAT, 32'h0, 1'b0},
    {`MPR_OFS_INT_CLR, 32'h0, 1'b0}, {`MPR_OFS_INT_EN, 32'h0, 1'b0}, {12'h018, 32'h0, 1'b1}};
  mpr_pause_ctrl u_dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .motion_cmd(cmd), .motor_moving(moving), .motion_done(done),
    .engine_remain(eng_rem), .launch(launch), .soft_stop_cmd(soft_stop_cmd),
    .stop_rate(stop_rate), .motion_end(motion_end), .pause_cmd(src[0]),
    .pause_pin(src[1]), .pause_remote(src[2]), .resume_motion(src[3]),
    .resume_pin(src[4]), .clear_paused_motion(src[5]), .clear_pause_input(src[6]),
    .start_in(src[7]), .seq_running(seq_running), .pause_status_flag(flag),
    .pause_status_signal(status_sig), .irq(irq));
  mpr_engine_model u_eng (.ref_clk(ref_clk), .resetn(resetn), .motion_cmd(cmd),
    .launch(launch), .soft_stop_cmd(soft_stop_cmd), .motor_moving(moving),
    .motion_done(done), .engine_remain(eng_rem));
  // --------------------------------------------------
  // Clock, event counters and hang guard
  // --------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Output pulses stand one cycle, so they are counted at every edge
  always @(posedge ref_clk) begin
    cyc++;
    if (launch.valid === 1'b1) begin
      n_launch++;
      last_trav = launch.travel;
    end
    if (motion_end === 1'b1) n_end++;
    if (soft_stop_cmd === 1'b1) n_stop++;
    if (cyc == 30000) begin
      err_count++;
      conclude();
    end
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic conclude();
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  // APB transfer: setup, then access held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    d = prdata;
    s0 = int'(pslverr);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pulse(input int i);
    @(posedge ref_clk);
    src[i] <= 1'b1;
    @(posedge ref_clk);
    src[i] <= 1'b0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : pulse
  task automatic go(input int k, input logic [31:0] t);
    @(posedge ref_clk);
    cmd <= '{1'b1, mpr_pkg::mpr_kind_e'(k[2:0]), t};
    @(posedge ref_clk);
    cmd.valid <= 1'b0;
    repeat (8) @(posedge ref_clk);
    {l0, e0, s0} = {n_launch, n_end, n_stop};
  endtask : go
  // Waits for the paused flag or a motion end, bounded
  task automatic halt(input int i);
    pulse(i);
    for (int j = 0; j < 40 && flag !== 1'b1 && n_end == e0; j++) @(negedge ref_clk);
    @(negedge ref_clk);
  endtask : halt
  task automatic run_out();
    for (int j = 0; j < 1200 && n_end == e0; j++) @(posedge ref_clk);
    check(32'(n_end), 32'(e0 + 1));
  endtask : run_out
  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata, src, seq_running} = '0;
    cmd = '0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (rows[r]) begin
      apb(1'b0, rows[r][44:33], 32'h0);
      check(d, rows[r][32:1]);
      check(32'(s0), 32'(rows[r][0]));
    end
    // Pause pin and remote still unassigned: their edges raise no event
    pulse(1);
    pulse(2);
    apb(1'b0, `MPR_OFS_INT_STAT, 32'h0);
    check(d, 32'h0);
    // Pause with nothing moving: no state change, only the ignored event
    pulse(0);
    check(32'(flag), 32'h0);
    apb(1'b0, `MPR_OFS_STATUS, 32'h0);
    check(d, 32'h1);
    check(32'(irq), 32'h0);
    apb(1'b1, `MPR_OFS_INT_EN, 32'hf);
    repeat (2) @(negedge ref_clk);
    check(32'(irq), 32'h1);
    apb(1'b1, `MPR_OFS_INT_CLR, 32'hf);
    apb(1'b0, `MPR_OFS_INT_STAT, 32'h0);
    check(d, 32'h0);
    check(32'(irq), 32'h0);
    // Pin, remote and output assigned; rate field for the ramp
    apb(1'b1, `MPR_OFS_CTRL, 32'h0000_100e);
    // Resumable kinds, paused by command, pin, remote, then command again
    for (int k = 0; k < 4; k++) begin
      go(k, 32'd1000);
      halt(k == 3 ? 0 : k);
      remain = eng_rem;
      check(32'(n_stop), 32'(s0 + 1));
      check(32'(stop_rate), 32'h10);
      check(32'(moving), 32'h0);
      check({flag, status_sig, irq}, 3'b111);
      apb(1'b0, `MPR_OFS_STATUS, 32'h0);
      check(d[6:0], {k[2:0], 4'h8});
      apb(1'b0, `MPR_OFS_REMAIN, 32'h0);
      check(d, remain);
      check(32'(n_end), 32'(e0));
      pulse(k[0] ? 4 : 3);
      check(32'(n_launch), 32'(l0 + 1));
      check(last_trav, remain);
      check(32'(launch.kind), 32'(k));
      check(32'(flag), 32'h0);
      run_out();
      apb(1'b1, `MPR_OFS_INT_CLR, 32'hf);
    end
    // Linked and homing moves: stop only, resume ignored
    for (int k = 4; k < 7; k++) begin
      go(k, 32'd1000);
      halt(0);
      check(32'(n_stop), 32'(s0 + 1));
      check(32'(n_end), 32'(e0 + 1));
      pulse(3);
      check(32'(n_launch), 32'(l0));
      check(32'(flag), 32'h0);
    end
    // Clear by command and by input while a sequence runs
    @(posedge ref_clk);
    seq_running <= 1'b1;
    for (int c = 5; c < 7; c++) begin
      go(0, 32'd1000);
      halt(0);
      pulse(c);
      check(32'(n_end), 32'(e0 + 1));
      check(32'(n_launch), 32'(l0));
      apb(1'b0, `MPR_OFS_REMAIN, 32'h0);
      check(d, 32'h0);
      apb(1'b0, `MPR_OFS_STATUS, 32'h0);
      check(d[3:0], 4'h1);
    end
    // Start input resumes only with select zero
    go(1, 32'd300);
    halt(0);
    pulse(7);
    check(32'(n_launch), 32'(l0 + 1));
    run_out();
    apb(1'b1, `MPR_OFS_CTRL, 32'h0000_100f);
    go(2, 32'd300);
    halt(0);
    pulse(7);
    check(32'(n_launch), 32'(l0));
    // New motion replaces the paused one without a motion end
    d = 32'(n_end);
    go(1, 32'd50);
    check(32'(flag), 32'h0);
    check(32'(n_end), d);
    run_out();
    // Reset in mid-pause: state, flag and stored travel go back to rest
    go(3, 32'd1000);
    halt(0);
    check(32'(flag), 32'h1);
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    check({flag, status_sig, irq, moving}, 4'h0);
    apb(1'b0, `MPR_OFS_STATUS, 32'h0);
    check(d, 32'h1);
    apb(1'b0, `MPR_OFS_REMAIN, 32'h0);
    check(d, 32'h0);
    conclude();
  end
endmodule : motion_pause_resume_control_test
